// file: rtl/bbcce_pkg.sv
// Package for the bit, branch, call and compare executor.
// Assumes a 32-bit AHB-Lite bus with word-aligned single transfers.
package bbcce_pkg;
  // ----------------------------------------------------------------
  // Bus map (byte offsets, haddr[11:0])
  // ----------------------------------------------------------------
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_STATUS = 12'h004;
  localparam logic [11:0] OFF_INSN = 12'h008;
  localparam logic [11:0] OFF_PC = 12'h00C;
  localparam logic [11:0] OFF_SP = 12'h010;
  localparam logic [11:0] OFF_FLAGS = 12'h014;
  localparam logic [1:0] REGION_CTL = 2'h0;
  localparam logic [1:0] REGION_RF = 2'h1;
  localparam logic [1:0] REGION_PM = 2'h2;
  localparam int CTRL_START = 0;
  localparam int STAT_BUSY = 0;
  localparam int STAT_BAD = 1;
  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_BTJ = 8'h37;
  localparam logic [7:0] OP_BIT_EXCLUSIVE_OR_OP = 8'h27;
  localparam logic [7:0] OP_CALL_DA = 8'hF6;
  localparam logic [7:0] OP_CALL_IRR = 8'hF4;
  localparam logic [7:0] OP_CALL_IA = 8'hD4;
  localparam logic [7:0] OP_CCF = 8'hEF;
  localparam logic [7:0] OP_CLR_R = 8'hB0;
  localparam logic [7:0] OP_CLR_IR = 8'hB1;
  localparam logic [7:0] OP_COM_R = 8'h60;
  localparam logic [7:0] OP_COM_IR = 8'h61;
  localparam logic [7:0] OP_CP_RR = 8'hA2;
  localparam logic [7:0] OP_CP_RIR = 8'hA3;
  localparam logic [7:0] OP_CP_FR = 8'hA4;
  localparam logic [7:0] OP_CP_FIR = 8'hA5;
  localparam logic [7:0] OP_CP_IM = 8'hA6;
  localparam logic [7:0] OP_RET = 8'hAF;
  // ----------------------------------------------------------------
  // Execution cycles
  // ----------------------------------------------------------------
  localparam logic [3:0] CYC_BTJ = 4'hA;
  localparam logic [3:0] CYC_BIT_EXCLUSIVE_OR_OP = 4'h6;
  localparam logic [3:0] CYC_CALL_LONG = 4'hE;
  localparam logic [3:0] CYC_CALL_IRR = 4'hC;
  localparam logic [3:0] CYC_SHORT = 4'h4;
  localparam logic [3:0] CYC_CP_LONG = 4'h6;
  localparam logic [3:0] CYC_RET = 4'h8;
  // ----------------------------------------------------------------
  // Flags layout, special addresses, reset values
  // ----------------------------------------------------------------
  localparam int FL_C = 7;
  localparam int FL_Z = 6;
  localparam int FL_S = 5;
  localparam int FL_V = 4;
  localparam logic [7:0] FLAGS_ADDR = 8'hD5;
  localparam logic [3:0] WREG_PAGE = 4'h0;
  localparam logic [15:0] PC_RST = 16'h0000;
  localparam logic [15:0] SP_RST = 16'h0000;
  localparam logic [7:0] FLAGS_RST = 8'h00;
  typedef enum logic [1:0] {
    ALU_XOR = 2'b00,
    ALU_COM = 2'b01,
    ALU_CP = 2'b10,
    ALU_NONE = 2'b11
  } bbcce_aluop_e;
  typedef enum logic {
    ST_IDLE = 1'b0,
    ST_EXEC = 1'b1
  } bbcce_state_e;
endpackage

// file: rtl/bbcce_alu_if.sv
// Interface between the executor core and its flag ALU.
// Assumes both ends sit in the hclk domain; purely combinational.
`timescale 1ns/1ps
interface bbcce_alu_if;
  bbcce_pkg::bbcce_aluop_e op;
  logic [7:0] a;
  logic [7:0] b;
  logic [2:0] bidx;
  logic sel;
  logic [7:0] flg_in;
  logic [7:0] res;
  logic [7:0] flg_out;
  modport core (output op, a, b, bidx, sel, flg_in, input res, flg_out);
  modport alu (input op, a, b, bidx, sel, flg_in, output res, flg_out);
endinterface

// file: rtl/bbcce_alu.sv
// Result and flag logic for bit XOR, complement and compare.
// Assumes operands are stable for the whole instruction.
`timescale 1ns/1ps
module bbcce_alu (
  bbcce_alu_if.alu p
);
  // ----------------------------------------------------------------
  // Operation
  // ----------------------------------------------------------------
  logic [8:0] diff;
  logic rbit;
  // Unselected flags pass through untouched
  always_comb
  begin
    p.res = p.a;
    p.flg_out = p.flg_in;
    diff = {1'b0, p.a} - {1'b0, p.b};
    rbit = 1'b0;
    case (p.op)
      bbcce_pkg::ALU_XOR:
      begin
        if (!p.sel)
        begin
          rbit = p.a[0] ^ p.b[p.bidx];
          p.res[0] = rbit;
        end
        else
        begin
          rbit = p.a[p.bidx] ^ p.b[0];
          p.res[p.bidx] = rbit;
        end
        // V is undefined, so it is simply kept
        p.flg_out[bbcce_pkg::FL_Z] = ~rbit;
        p.flg_out[bbcce_pkg::FL_S] = 1'b0;
      end
      bbcce_pkg::ALU_COM:
      begin
        p.res = ~p.a;
        p.flg_out[bbcce_pkg::FL_Z] = (p.a == 8'hFF);
        p.flg_out[bbcce_pkg::FL_S] = ~p.a[7];
        p.flg_out[bbcce_pkg::FL_V] = 1'b0;
      end
      bbcce_pkg::ALU_CP:
      begin
        p.flg_out[bbcce_pkg::FL_C] = diff[8];
        p.flg_out[bbcce_pkg::FL_Z] = (diff[7:0] == 8'h00);
        p.flg_out[bbcce_pkg::FL_S] = diff[7];
        p.flg_out[bbcce_pkg::FL_V] = (p.a[7] ^ p.b[7]) & (p.a[7] ^ diff[7]);
      end
      default:
      begin
        p.res = p.a;
      end
    endcase
  end
endmodule

// file: rtl/bbcce_core.sv
// Executor for one slice of an 8-bit core's instruction set.
// Assumes an AHB-Lite master, one slave, single word transfers.
//
// Summary of operation
// - Selector 0: branch when tested bit is zero; 3 bytes, 10 cycles
// - Opcode 37 selector 1: branch when tested bit is one
// - Second byte: register 4 bits, bit index 3 bits, selector 1 bit
// - Bit-test branches never change flags
// - Branch displacement is a signed byte, +127 to -128
// - Bit XOR writes only target bit; 3 bytes, 6 cycles
// - Bit XOR: Z from result, S cleared, V undefined, others kept
// - Call pushes low then high byte of next address, loads target
// - Vector call reads target from program memory, high byte first
// - Return pops two stacked bytes into the program counter
// - Carry flip inverts C only; 1 byte, 4 cycles
// - Clear writes zero, direct or pointer, no flags; 4 cycles
// - Complement inverts destination, direct or pointer; 4 cycles
// - Complement: Z on zero, S from bit 7, V cleared
// - Compare sets flags only; short form 4 cycles, others 6
// - Compare: C borrow, Z equal, S negative, V overflow
// - Flags register lives at register address D5
//
// Local design decisions: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
module bbcce_core (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  logic [7:0] rf_q [256];
  logic [7:0] pm_q [256];
  logic [23:0] insn_q;
  logic [15:0] pc_q;
  logic [15:0] sp_q;
  logic [7:0] flags_q;
  logic [3:0] cnt_q;
  logic bad_q;
  bbcce_pkg::bbcce_state_e state_q;
  logic dp_wr_q;
  logic [11:0] dp_addr_q;
  logic busy;
  logic commit;
  bbcce_alu_if alu ();

  bbcce_alu u_alu (
    .p(alu)
  );

  // Register read with the flags register mapped in at D5
  function automatic logic [7:0] rd(input logic [7:0] addr,
                                     input logic [7:0] fl);
    rd = (addr == bbcce_pkg::FLAGS_ADDR) ? fl : rf_q[addr];
  endfunction

  function automatic logic [7:0] wreg(input logic [3:0] r);
    wreg = {bbcce_pkg::WREG_PAGE, r};
  endfunction

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  logic [7:0] op;
  logic [7:0] b2;
  logic [7:0] b3;
  logic [1:0] len;
  logic [3:0] cyc;
  logic legal;
  logic [15:0] pc_seq;
  logic [15:0] pc_d;
  logic [15:0] sp_d;
  logic [7:0] fl_d;
  logic wa_en;
  logic [7:0] wa_a;
  logic [7:0] wa_v;
  logic wb_en;
  logic [7:0] wb_a;
  logic [7:0] wb_v;
  logic [7:0] ptr;
  logic tbit;

  assign op = insn_q[7:0];
  assign b2 = insn_q[15:8];
  assign b3 = insn_q[23:16];
  assign busy = (state_q == bbcce_pkg::ST_EXEC);
  assign commit = busy && (cnt_q == 4'h0);
  assign pc_seq = pc_q + {14'h0000, len};

  // Length and duration of each opcode
  always_comb
  begin
    len = 2'd2;
    cyc = bbcce_pkg::CYC_SHORT;
    legal = 1'b1;
    case (op)
      bbcce_pkg::OP_BTJ:
      begin
        len = 2'd3;
        cyc = bbcce_pkg::CYC_BTJ;
      end
      bbcce_pkg::OP_BIT_EXCLUSIVE_OR_OP:
      begin
        len = 2'd3;
        cyc = bbcce_pkg::CYC_BIT_EXCLUSIVE_OR_OP;
      end
      bbcce_pkg::OP_CALL_DA:
      begin
        len = 2'd3;
        cyc = bbcce_pkg::CYC_CALL_LONG;
      end
      bbcce_pkg::OP_CALL_IRR: cyc = bbcce_pkg::CYC_CALL_IRR;
      bbcce_pkg::OP_CALL_IA: cyc = bbcce_pkg::CYC_CALL_LONG;
      bbcce_pkg::OP_CCF: len = 2'd1;
      bbcce_pkg::OP_CLR_R, bbcce_pkg::OP_CLR_IR,
      bbcce_pkg::OP_COM_R, bbcce_pkg::OP_COM_IR,
      bbcce_pkg::OP_CP_RR: cyc = bbcce_pkg::CYC_SHORT;
      bbcce_pkg::OP_CP_RIR: cyc = bbcce_pkg::CYC_CP_LONG;
      bbcce_pkg::OP_CP_FR, bbcce_pkg::OP_CP_FIR, bbcce_pkg::OP_CP_IM:
      begin
        len = 2'd3;
        cyc = bbcce_pkg::CYC_CP_LONG;
      end
      bbcce_pkg::OP_RET:
      begin
        len = 2'd1;
        cyc = bbcce_pkg::CYC_RET;
      end
      default: legal = 1'b0;
    endcase
  end

  // Effects of each opcode, applied when the count runs out
  always_comb
  begin
    pc_d = pc_seq;
    sp_d = sp_q;
    wa_en = 1'b0;
    wa_a = 8'h00;
    wa_v = 8'h00;
    wb_en = 1'b0;
    wb_a = 8'h00;
    wb_v = 8'h00;
    ptr = 8'h00;
    tbit = 1'b0;
    alu.op = bbcce_pkg::ALU_NONE;
    alu.a = 8'h00;
    alu.b = 8'h00;
    alu.bidx = b2[3:1];
    alu.sel = b2[0];
    alu.flg_in = flags_q;
    fl_d = flags_q;
    case (op)
      bbcce_pkg::OP_BTJ:
      begin
        // Taken when the bit equals the selector; flags held
        ptr = rd(wreg(b2[7:4]), flags_q);
        tbit = ptr[b2[3:1]];
        if (tbit == b2[0])
          pc_d = pc_seq + {{8{b3[7]}}, b3};
      end
      bbcce_pkg::OP_BIT_EXCLUSIVE_OR_OP:
      begin
        alu.op = bbcce_pkg::ALU_XOR;
        wa_en = 1'b1;
        wa_a = b2[0] ? b3 : wreg(b2[7:4]);
        alu.a = rd(wa_a, flags_q);
        alu.b = rd(b2[0] ? wreg(b2[7:4]) : b3, flags_q);
        wa_v = alu.res;
        fl_d = alu.flg_out;
      end
      bbcce_pkg::OP_CALL_DA, bbcce_pkg::OP_CALL_IRR,
      bbcce_pkg::OP_CALL_IA:
      begin
        // Low byte goes one below SP, high byte two below
        wa_en = 1'b1;
        wa_a = 8'(sp_q - 16'h0001);
        wa_v = pc_seq[7:0];
        wb_en = 1'b1;
        wb_a = 8'(sp_q - 16'h0002);
        wb_v = pc_seq[15:8];
        sp_d = sp_q - 16'h0002;
        if (op == bbcce_pkg::OP_CALL_DA)
          pc_d = {b2, b3};
        else if (op == bbcce_pkg::OP_CALL_IRR)
          pc_d = {rd(b2, flags_q), rd(8'(b2 + 8'h01), flags_q)};
        else
          pc_d = {pm_q[b2], pm_q[8'(b2 + 8'h01)]};
      end
      bbcce_pkg::OP_CCF:
        fl_d[bbcce_pkg::FL_C] = ~flags_q[bbcce_pkg::FL_C];
      bbcce_pkg::OP_CLR_R, bbcce_pkg::OP_CLR_IR:
      begin
        wa_en = 1'b1;
        wa_a = (op == bbcce_pkg::OP_CLR_IR) ? rd(b2, flags_q) : b2;
        wa_v = 8'h00;
      end
      bbcce_pkg::OP_COM_R, bbcce_pkg::OP_COM_IR:
      begin
        alu.op = bbcce_pkg::ALU_COM;
        wa_en = 1'b1;
        wa_a = (op == bbcce_pkg::OP_COM_IR) ? rd(b2, flags_q) : b2;
        alu.a = rd(wa_a, flags_q);
        wa_v = alu.res;
        fl_d = alu.flg_out;
      end
      bbcce_pkg::OP_CP_RR, bbcce_pkg::OP_CP_RIR:
      begin
        alu.op = bbcce_pkg::ALU_CP;
        alu.a = rd(wreg(b2[7:4]), flags_q);
        ptr = rd(wreg(b2[3:0]), flags_q);
        alu.b = (op == bbcce_pkg::OP_CP_RIR) ? rd(ptr, flags_q) : ptr;
        fl_d = alu.flg_out;
      end
      bbcce_pkg::OP_CP_FR, bbcce_pkg::OP_CP_FIR:
      begin
        alu.op = bbcce_pkg::ALU_CP;
        alu.a = rd(b3, flags_q);
        ptr = rd(b2, flags_q);
        alu.b = (op == bbcce_pkg::OP_CP_FIR) ? rd(ptr, flags_q) : ptr;
        fl_d = alu.flg_out;
      end
      bbcce_pkg::OP_CP_IM:
      begin
        alu.op = bbcce_pkg::ALU_CP;
        alu.a = rd(b2, flags_q);
        alu.b = b3;
        fl_d = alu.flg_out;
      end
      bbcce_pkg::OP_RET:
      begin
        // High byte sits at SP, low byte just above it
        pc_d = {rd(sp_q[7:0], flags_q),
                rd(8'(sp_q[7:0] + 8'h01), flags_q)};
        sp_d = sp_q + 16'h0002;
      end
      default: pc_d = pc_q;
    endcase
    // A plain write on the wa port landing on D5 replaces the flags; a wb write there does not
    if (wa_en && wa_a == bbcce_pkg::FLAGS_ADDR &&
        alu.op == bbcce_pkg::ALU_NONE)
      fl_d = wa_v;
  end

  // ----------------------------------------------------------------
  // Bus slave
  // ----------------------------------------------------------------
  logic ap;
  logic bus_we;
  logic [31:0] rdata;

  assign ap = hsel && hready && htrans[1];
  assign bus_we = dp_wr_q && !busy;
  // Zero wait states, every answer OKAY
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  // Address phase capture
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dp_wr_q <= 1'b0;
      dp_addr_q <= 12'h000;
    end
    else if (hready)
    begin
      dp_wr_q <= ap && hwrite;
      dp_addr_q <= haddr[11:0];
    end
  end

  // Read mux; unmapped offsets read as zero
  always_comb
  begin
    rdata = 32'h0000_0000;
    case (haddr[11:10])
      bbcce_pkg::REGION_CTL:
        case (haddr[11:0])
          bbcce_pkg::OFF_STATUS: rdata = {30'h0, bad_q, busy};
          bbcce_pkg::OFF_INSN: rdata = {8'h00, insn_q};
          bbcce_pkg::OFF_PC: rdata = {16'h0000, pc_q};
          bbcce_pkg::OFF_SP: rdata = {16'h0000, sp_q};
          bbcce_pkg::OFF_FLAGS: rdata = {24'h000000, flags_q};
          default: rdata = 32'h0000_0000;
        endcase
      bbcce_pkg::REGION_RF: rdata = {24'h000000, rd(haddr[9:2], flags_q)};
      bbcce_pkg::REGION_PM: rdata = {24'h000000, pm_q[haddr[9:2]]};
      default: rdata = 32'h0000_0000;
    endcase
  end

  // Read data registered at the end of the address phase
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (ap && !hwrite)
      hrdata <= rdata;
  end

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  logic start;
  assign start = bus_we && dp_addr_q == bbcce_pkg::OFF_CTRL &&
                 hwdata[bbcce_pkg::CTRL_START];

  // Busy for exactly the documented cycle count of the opcode
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      state_q <= bbcce_pkg::ST_IDLE;
      cnt_q <= 4'h0;
      bad_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        bbcce_pkg::ST_IDLE:
          if (start)
          begin
            bad_q <= !legal;
            if (legal)
            begin
              state_q <= bbcce_pkg::ST_EXEC;
              cnt_q <= cyc - 4'h1;
            end
          end
        bbcce_pkg::ST_EXEC:
          if (cnt_q == 4'h0)
            state_q <= bbcce_pkg::ST_IDLE;
          else
            cnt_q <= cnt_q - 4'h1;
        default: state_q <= bbcce_pkg::ST_IDLE;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Architectural registers
  // ----------------------------------------------------------------
  // Software may only load these while the core is idle
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      insn_q <= 24'h000000;
      pc_q <= bbcce_pkg::PC_RST;
      sp_q <= bbcce_pkg::SP_RST;
      flags_q <= bbcce_pkg::FLAGS_RST;
    end
    else if (commit)
    begin
      pc_q <= pc_d;
      sp_q <= sp_d;
      flags_q <= fl_d;
    end
    else if (bus_we)
    begin
      if (dp_addr_q == bbcce_pkg::OFF_INSN)
        insn_q <= hwdata[23:0];
      if (dp_addr_q == bbcce_pkg::OFF_PC)
        pc_q <= hwdata[15:0];
      if (dp_addr_q == bbcce_pkg::OFF_SP)
        sp_q <= hwdata[15:0];
      if (dp_addr_q == bbcce_pkg::OFF_FLAGS ||
          (dp_addr_q[11:10] == bbcce_pkg::REGION_RF &&
           dp_addr_q[9:2] == bbcce_pkg::FLAGS_ADDR))
        flags_q <= hwdata[7:0];
    end
  end

  // Memories carry no reset; software loads them before use
  always_ff @(posedge hclk)
  begin
    if (commit)
    begin
      if (wa_en)
        rf_q[wa_a] <= wa_v;
      if (wb_en)
        rf_q[wb_a] <= wb_v;
    end
    else if (bus_we)
    begin
      if (dp_addr_q[11:10] == bbcce_pkg::REGION_RF)
        rf_q[dp_addr_q[9:2]] <= hwdata[7:0];
      if (dp_addr_q[11:10] == bbcce_pkg::REGION_PM)
        pm_q[dp_addr_q[9:2]] <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  branch_flags_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    commit && op == bbcce_pkg::OP_BTJ |=> flags_q == $past(flags_q))
    else $error("bit-test branch changed flags");

  branch_target_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    commit && op == bbcce_pkg::OP_BTJ |=>
      pc_q == $past(pc_q) + 16'h0003 +
      (($past(tbit) == $past(b2[0])) ? {{8{$past(b3[7])}}, $past(b3)}
                                      : 16'h0000))
    else $error("branch target wrong");

  ccf_timing_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    start && !busy && op == bbcce_pkg::OP_CCF |=>
      busy [*4] ##1 !busy &&
      flags_q == ($past(flags_q, 5) ^ 8'h80))
    else $error("carry flip timing or value wrong");

  btj_timing_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    start && !busy && op == bbcce_pkg::OP_BTJ |=>
      busy [*8] ##1 busy [*2] ##1 !busy)
    else $error("bit-test branch not ten cycles");

  call_push_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    commit && op == bbcce_pkg::OP_CALL_DA |=>
      sp_q == $past(sp_q) - 16'h0002 && pc_q == {$past(b2), $past(b3)} &&
      rf_q[8'($past(sp_q) - 16'h0002)] == $past(pc_seq[15:8]))
    else $error("call push wrong");

  com_flags_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    commit && op == bbcce_pkg::OP_COM_R |=>
      !flags_q[bbcce_pkg::FL_V] &&
      flags_q[bbcce_pkg::FL_S] == ~$past(alu.a[7]) &&
      flags_q[bbcce_pkg::FL_C] == $past(flags_q[bbcce_pkg::FL_C]))
    else $error("complement flags wrong");

  cp_flags_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    commit && op == bbcce_pkg::OP_CP_IM |=>
      flags_q[bbcce_pkg::FL_C] == ($past(alu.b) > $past(alu.a)) &&
      flags_q[bbcce_pkg::FL_Z] == ($past(alu.b) == $past(alu.a)))
    else $error("compare flags wrong");

  bit_exclusive_or_op_flags_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    commit && op == bbcce_pkg::OP_BIT_EXCLUSIVE_OR_OP |=>
      !flags_q[bbcce_pkg::FL_S] &&
      flags_q[bbcce_pkg::FL_C] == $past(flags_q[bbcce_pkg::FL_C]))
    else $error("bit xor flags wrong");

  clr_zero_a: assert property (
    @(posedge hclk) disable iff (!hresetn)
    commit && op == bbcce_pkg::OP_CLR_R &&
    b2 != bbcce_pkg::FLAGS_ADDR |=>
      rf_q[$past(b2)] == 8'h00 && flags_q == $past(flags_q))
    else $error("clear wrong");
endmodule

// file: testbench/testbench.sv
// Self-checking bench for the bit, branch, call and compare executor.
// Drives the AHB-Lite port directly; hready is looped from hreadyout.
`timescale 1ns/1ps
module testbench;
  localparam logic [7:0] PX = 8'h4C;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic hresp;
  logic [31:0] hrdata;
  logic [31:0] seed = 32'h85BE;
  logic [31:0] r;
  logic [31:0] v;
  logic [7:0] a, b, c, e, f, g, h, t, ev, ad;
  logic [15:0] p, q, s, n;
  int err_count = 0;
  int cmp_count = 0;
  logic [7:0] ops[3] = '{8'hF6, 8'hF4, 8'hD4};
  logic [7:0] sops[12] = '{8'hEF, 8'hB0, 8'hB1, 8'h60, 8'h61, 8'h61,
    8'hA2, 8'hA2, 8'hA6, 8'hA3, 8'hA4, 8'hA5};

  // ------------------------------------------------------------------
  // Clock and device
  // ------------------------------------------------------------------
  // Free-running 50 MHz clock
  always #10 hclk = ~hclk;

  bbcce_core u_dut (
    .hclk(hclk),
    .hresetn(hresetn),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hreadyout),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata)
  );

  // ------------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------------
  // Xorshift keeps the random run repeatable
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic test_done();
    $display("Compares %0d, mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t saw %h want %h", $time, seen, exp);
    end
  endtask

  // A stuck wait is a mismatch and ends the run at once
  task automatic hang(input string m);
    err_count++;
    $display("BAD %0t %s", $time, m);
    test_done();
  endtask

  task automatic hwait();
    int i;
    for (i = 0; i < 20; i++)
    begin
      @(posedge hclk);
      if (hreadyout === 1'b1)
        break;
    end
    if (i == 20)
      hang("bus stuck");
  endtask

  // One single transfer; the next one starts an edge later, so an IDLE
  // cycle always separates transfers
  task automatic bus(input logic w, input logic [11:0] ad,
    input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {20'h0, ad};
    hwrite <= w;
    hwait();
    htrans <= 2'h0;
    hwdata <= wd;
    hwait();
    v = hrdata;
    chk({31'h0, hresp}, 32'h0);
  endtask

  task automatic wr(input logic [11:0] ad, input logic [31:0] wd);
    bus(1'b1, ad, wd);
  endtask

  task automatic rd(input logic [11:0] ad);
    bus(1'b0, ad, 32'h0);
  endtask

  task automatic rw(input logic [7:0] ra, input logic [7:0] d);
    wr({2'h1, ra, 2'h0}, {24'h0, d});
  endtask

  task automatic rr(input logic [7:0] ra);
    rd({2'h1, ra, 2'h0});
  endtask

  task automatic pw(input logic [7:0] ra, input logic [7:0] d);
    wr({2'h2, ra, 2'h0}, {24'h0, d});
  endtask

  // Load, start, poll to completion, then check PC and both flag views
  task automatic go(input logic [23:0] ins, input logic [15:0] pc,
    input logic [7:0] fl, input logic [15:0] epc, input logic [7:0] efl);
    wr(bbcce_pkg::OFF_INSN, {8'h0, ins});
    wr(bbcce_pkg::OFF_PC, {16'h0, pc});
    wr(bbcce_pkg::OFF_FLAGS, {24'h0, fl});
    wr(bbcce_pkg::OFF_CTRL, 32'h1);
    rd(bbcce_pkg::OFF_STATUS);
    chk(v, 32'h1);
    for (int i = 0; i < 40 && v[0] !== 1'b0; i++)
      rd(bbcce_pkg::OFF_STATUS);
    if (v[0] !== 1'b0)
      hang("busy stuck");
    rd(bbcce_pkg::OFF_PC);
    chk(v, {16'h0, epc});
    rd(bbcce_pkg::OFF_FLAGS);
    chk(v, {24'h0, efl});
    rr(8'hD5);
    chk(v, {24'h0, efl});
  endtask

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial
  begin
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    // Unmapped offset reads zero and ignores writes
    wr(12'hFF0, 32'hFFFFFFFF);
    rd(12'hFF0);
    chk(v, 32'h0);
    // Unknown opcode flags itself and never goes busy
    wr(bbcce_pkg::OFF_INSN, 32'h0);
    wr(bbcce_pkg::OFF_CTRL, 32'h1);
    rd(bbcce_pkg::OFF_STATUS);
    chk(v, 32'h2);
    // Bit-test branches, both selectors, displacement extremes first
    for (int k = 0; k < 8; k++)
    begin
      r = rnd();
      a = r[7:0];
      b = {r[15:9], k[0]};
      c = (k == 0) ? 8'h7F : (k == 1) ? 8'h80 : r[23:16];
      f = r[31:24];
      p = 16'(rnd());
      rw({4'h0, b[7:4]}, a);
      q = (a[b[3:1]] == b[0]) ? {{8{c[7]}}, c} : 16'h0;
      q = p + 16'h3 + q;
      go({c, b, 8'h37}, p, f, q, f);
    end
    $display("Test branch done");
    // Bit XOR in both operand orders
    for (int k = 0; k < 4; k++)
    begin
      r = rnd();
      b = {r[11:8], r[14:12], k[0]};
      c = {4'h1, r[7:4]};
      a = r[23:16];
      t = r[31:24];
      f = r[7:0] ^ r[31:24];
      p = 16'(rnd());
      rw({4'h0, b[7:4]}, a);
      rw(c, t);
      g = f;
      g[bbcce_pkg::FL_Z] = ~(a[0] ^ t[b[3:1]]);
      g[bbcce_pkg::FL_S] = 1'b0;
      if (b[0])
        t[b[3:1]] = a[0] ^ t[b[3:1]];
      else
        a[0] = a[0] ^ t[b[3:1]];
      go({c, b, 8'h27}, p, f, p + 16'h3, g);
      rr({4'h0, b[7:4]});
      chk(v, {24'h0, a});
      rr(c);
      chk(v, {24'h0, t});
    end
    $display("Test bit xor done");
    // Every call form, each undone by a return
    foreach (ops[k])
    begin
      r = rnd();
      t = ops[k];
      a = {3'h1, r[20:17], 1'b0};
      s = {8'h0, 3'h3, r[28:24]};
      f = r[31:24];
      p = 16'(rnd());
      q = p + ((t == 8'hF6) ? 16'h3 : 16'h2);
      rw(a, r[7:0]);
      rw(a + 8'h1, r[15:8]);
      pw(a, r[7:0]);
      pw(a + 8'h1, r[15:8]);
      wr(bbcce_pkg::OFF_SP, {16'h0, s});
      n = {r[7:0], r[15:8]};
      go((t == 8'hF6) ? {r[15:0], t} : {8'h0, a, t}, p, f, n, f);
      rd(bbcce_pkg::OFF_SP);
      chk(v, {16'h0, s - 16'h2});
      rr(s[7:0] - 8'h1);
      chk(v, {24'h0, q[7:0]});
      rr(s[7:0] - 8'h2);
      chk(v, {24'h0, q[15:8]});
      go({16'h0, 8'hAF}, n, f, q, f);
      rd(bbcce_pkg::OFF_SP);
      chk(v, {16'h0, s});
    end
    $display("Test call done");
    // Short operations; corners give a zero complement, overflow, equal
    foreach (sops[k])
    begin
      r = rnd();
      t = sops[k];
      a = (k == 5) ? 8'hFF : (k == 7) ? 8'h80 : r[7:0];
      c = (k == 7) ? 8'h01 : (k == 8) ? a : r[15:8];
      f = r[23:16];
      p = 16'(rnd());
      rw(PX, t[0] ? PX + 8'h1 : a);
      rw(PX + 8'h1, a);
      rw(8'h0C, a);
      // Pointer forms reach the source in 0E through register 0D
      rw(8'h0D, (t[7:4] == 4'hA && t[0]) ? 8'h0E : c);
      rw(8'h0E, c);
      ad = t[0] ? PX + 8'h1 : PX;
      b = PX;
      ev = a;
      h = c;
      g = f;
      n = 16'h2;
      if (t == 8'hEF)
      begin
        g[bbcce_pkg::FL_C] = ~f[bbcce_pkg::FL_C];
        n = 16'h1;
      end
      if (t[7:4] == 4'hB)
        ev = 8'h0;
      if (t[7:4] == 4'h6)
      begin
        ev = ~a;
        g[bbcce_pkg::FL_Z] = (ev == 8'h0);
        g[bbcce_pkg::FL_S] = ev[7];
        g[bbcce_pkg::FL_V] = 1'b0;
      end
      if (t[7:4] == 4'hA)
      begin
        e = a - c;
        ad = 8'h0C;
        b = t[2] ? (t[1] ? 8'h0C : 8'h0D) : 8'hCD;
        if (t[2] && !t[1])
          h = 8'h0C;
        n = t[2] ? 16'h3 : 16'h2;
        g[bbcce_pkg::FL_C] = (c > a);
        g[bbcce_pkg::FL_Z] = (e == 8'h0);
        g[bbcce_pkg::FL_S] = e[7];
        g[bbcce_pkg::FL_V] = (a[7] != c[7]) && (e[7] != a[7]);
      end
      go({h, b, t}, p, f, p + n, g);
      rr(ad);
      chk(v, {24'h0, ev});
    end
    $display("Test short ops done");
    test_done();
  end
endmodule
